// *** viu_core.sv ***
// Purpose: Interrupt and trap handling unit beside an 8-bit CPU core.
// Assumes: CPU core reports fetches, instructions and sampling points as pulses.
// Notes:   One clock per T-state; the CPU performs stacking and table reads.
`timescale 1ns/100ps
module viu_core
  import viu_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // External request pins, active low
  input wire logic i_nonmaskable_n,
  input wire logic i_maskable_request_level0_n,
  input wire logic i_maskable_request_level1_n,
  input wire logic i_maskable_request_level2_n,
  // Data bus during acknowledge
  input wire logic [7:0] i_data_bus,
  // Internal peripheral requests and their own enables
  input wire logic [6:0] i_periph_req,
  input wire logic [6:0] i_periph_en,
  // CPU core events
  input wire viu_cpu_evt_t i_evt,
  // Internal I/O access
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_rd,
  input wire logic i_io_wr,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_hit,
  // CPU core answer
  output viu_cpu_out_t o_cpu,
  // Bus strobes, active low
  output logic o_opcode_fetch_strobe_n,
  output logic o_io_request_strobe_n,
  // Wait states requested on the current cycle
  output logic o_wait_req
);

  // ----------------------------------------------------------------------------
  // State of the unit
  // ----------------------------------------------------------------------------
  typedef struct packed {
    viu_state_t st;
    logic [2:0] cnt;
    logic ack_mode2;
    logic nmi_prev;
    logic nmi_pend;
    logic last_ed;
    logic trap;
    logic ufo;
    logic [2:0] ite;
    logic [7:0] vec_low;
    logic [7:0] opmode;
    logic [1:0] reloc;
    logic [1:0] irq_mode;
    logic [7:0] rdata;
    logic hit;
    viu_cpu_out_t cpu;
    logic fetch_n;
    logic ioreq_n;
    logic wait_req;
  } viu_core_t;

  viu_core_t s_r;
  viu_core_t s_nxt;
  logic [3:0] pins_sync;
  logic [VIU_NUM_VEC-1:0] vec_req;
  logic [3:0] vec_idx;
  logic io_in_page;
  logic [5:0] io_off;
  logic maskable_request_level0_ok;
  logic nmi_edge;

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  viu_sync #(
    .W(4)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_pin({i_maskable_request_level2_n, i_maskable_request_level1_n,
            i_maskable_request_level0_n, i_nonmaskable_n}),
    .o_sync(pins_sync)
  );

  // ----------------------------------------------------------------------------
  // Request qualification
  // ----------------------------------------------------------------------------
  // falling edge
  assign nmi_edge = s_r.nmi_prev & ~pins_sync[0];
  assign maskable_request_level0_ok = ~pins_sync[1] & s_r.cpu.global_irq_enable_flag & s_r.ite[0];
  assign vec_req = {i_periph_req & i_periph_en,
                    ~pins_sync[3] & s_r.ite[2], ~pins_sync[2] & s_r.ite[1]}
                   & {VIU_NUM_VEC{s_r.cpu.global_irq_enable_flag}};
  assign vec_idx = viu_first(vec_req);
  assign io_in_page = (i_io_addr[15:8] == VIU_IO_PAGE_HI) && (i_io_addr[7:6] == s_r.reloc);
  assign io_off = i_io_addr[5:0];

  // ----------------------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Pulses last one cycle.
    s_nxt.cpu.take = 1'b0;
    s_nxt.cpu.push_pc = 1'b0;
    s_nxt.cpu.jump = 1'b0;
    s_nxt.cpu.vec_read = 1'b0;
    s_nxt.cpu.mode0_valid = 1'b0;
    s_nxt.cpu.dma_master_clear = 1'b0;
    s_nxt.hit = 1'b0;
    s_nxt.nmi_prev = pins_sync[0];

    // Register reads answer one cycle after the strobe.
    s_nxt.rdata = 8'h00;
    if (i_io_rd && io_in_page) begin
      case (io_off)
        VIU_OFF_VEC_LOW: begin
          s_nxt.hit = 1'b1;
          s_nxt.rdata = {s_r.vec_low[7:5], 5'h00};
        end
        VIU_OFF_TRAP_CTL: begin
          s_nxt.hit = 1'b1;
          s_nxt.rdata = VIU_TC_FIXED_ONES | {s_r.trap, s_r.ufo, 3'h0, s_r.ite};
        end
        VIU_OFF_OPMODE: begin
          s_nxt.hit = 1'b1;
          s_nxt.rdata = s_r.opmode;
        end
        VIU_OFF_IOCTL: begin
          s_nxt.hit = 1'b1;
          s_nxt.rdata = {s_r.reloc, 6'h1F};
        end
        default: begin
          s_nxt.rdata = 8'h00;
        end
      endcase
    end

    // Register writes; the trap flag can only be cleared by software.
    if (i_io_wr && io_in_page) begin
      case (io_off)
        VIU_OFF_VEC_LOW: begin
          s_nxt.vec_low = {i_io_wdata[7:5], 5'h00};
        end
        VIU_OFF_TRAP_CTL: begin
          s_nxt.ite = i_io_wdata[2:0];
          if (!i_io_wdata[VIU_TC_TRAP]) begin
            s_nxt.trap = 1'b0;
          end
        end
        VIU_OFF_OPMODE: begin
          s_nxt.opmode = i_io_wdata;
        end
        VIU_OFF_IOCTL: begin
          s_nxt.reloc = i_io_wdata[7:6];
        end
        default: begin
          s_nxt.hit = s_nxt.hit;
        end
      endcase
    end

    if (i_evt.ld_vec_page) begin
      s_nxt.cpu.vector_page = i_evt.acc;
    end
    if (i_evt.ld_acc_ir) begin
      s_nxt.cpu.pv_flag = s_r.cpu.saved_irq_enable_flag;
    end
    if (i_evt.mode_sel) begin
      s_nxt.irq_mode = i_evt.mode_val;
    end
    if (i_evt.enable_instr) begin
      s_nxt.cpu.global_irq_enable_flag = 1'b1;
      s_nxt.cpu.saved_irq_enable_flag = 1'b1;
    end
    if (i_evt.disable_instr) begin
      s_nxt.cpu.global_irq_enable_flag = 1'b0;
      s_nxt.cpu.saved_irq_enable_flag = 1'b0;
    end
    if (i_evt.ret_nmi_instr) begin
      s_nxt.cpu.global_irq_enable_flag = s_r.cpu.saved_irq_enable_flag;
    end

    // The edge is held until served; a new edge in the serving cycle is kept.
    if (nmi_edge) begin
      s_nxt.nmi_pend = 1'b1;
    end

    // Fetch strobe follows the CPU fetch only while full fetch strobes are enabled.
    s_nxt.fetch_n = ~(i_evt.m1_cycle & s_r.opmode[VIU_OPM_FULL_FETCH]);
    s_nxt.ioreq_n = 1'b1;
    s_nxt.wait_req = 1'b0;

    if (i_evt.fetch) begin
      s_nxt.last_ed = (i_evt.fetch_byte == VIU_OP_PREFIX_ED);
    end

    case (s_r.st)
      VIU_ST_IDLE: begin
        s_nxt.cpu.ack_busy = 1'b0;
        s_nxt.cpu.return_from_maskable_refetch = 1'b0;
        if (i_evt.fetch && i_evt.fetch_undef) begin
          s_nxt.trap = 1'b1;
          s_nxt.ufo = i_evt.undef_second;
          s_nxt.cpu.take = 1'b1;
          s_nxt.cpu.push_pc = 1'b1;
          s_nxt.cpu.jump = 1'b1;
          s_nxt.cpu.target = VIU_ADDR_TRAP;
        end else if (i_evt.fetch && s_r.last_ed && i_evt.fetch_byte == VIU_OP_RET_MASKABLE) begin
          s_nxt.st = VIU_ST_REFETCH;
          s_nxt.cnt = VIU_REFETCH_TSTATES;
          s_nxt.cpu.return_from_maskable_refetch = 1'b1;
          s_nxt.fetch_n = 1'b0;
          s_nxt.last_ed = 1'b0;
        end else if (i_evt.sample && (s_r.nmi_pend || nmi_edge)) begin
          s_nxt.nmi_pend = nmi_edge & s_r.nmi_pend;
          s_nxt.cpu.dma_master_clear = 1'b1;
          s_nxt.cpu.take = 1'b1;
          s_nxt.cpu.push_pc = 1'b1;
          s_nxt.cpu.jump = 1'b1;
          s_nxt.cpu.target = VIU_ADDR_NMI;
          s_nxt.cpu.saved_irq_enable_flag = s_r.cpu.global_irq_enable_flag;
          s_nxt.cpu.global_irq_enable_flag = 1'b0;
        end else if (i_evt.sample && maskable_request_level0_ok) begin
          s_nxt.cpu.global_irq_enable_flag = 1'b0;
          s_nxt.cpu.saved_irq_enable_flag = 1'b0;
          if (s_r.irq_mode == 2'h1) begin
            s_nxt.cpu.take = 1'b1;
            s_nxt.cpu.push_pc = 1'b1;
            s_nxt.cpu.jump = 1'b1;
            s_nxt.cpu.target = VIU_ADDR_MODE1;
          end else begin
            s_nxt.st = VIU_ST_ACK_T1;
            s_nxt.ack_mode2 = (s_r.irq_mode == 2'h2);
            s_nxt.cpu.ack_busy = 1'b1;
            s_nxt.fetch_n = 1'b0;
          end
        end else if (i_evt.sample && (vec_req != '0)) begin
          s_nxt.cpu.global_irq_enable_flag = 1'b0;
          s_nxt.cpu.saved_irq_enable_flag = 1'b0;
          s_nxt.cpu.take = 1'b1;
          s_nxt.cpu.push_pc = 1'b1;
          s_nxt.cpu.vec_read = 1'b1;
          s_nxt.cpu.target = {s_r.cpu.vector_page, s_r.vec_low[7:5], viu_fixed_code(vec_idx)};
        end
      end
      VIU_ST_ACK_T1: begin
        s_nxt.st = VIU_ST_ACK_T2;
        s_nxt.fetch_n = 1'b0;
        s_nxt.ioreq_n = 1'b0;
        s_nxt.wait_req = 1'b1;
        s_nxt.cnt = VIU_ACK_WAITS;
      end
      VIU_ST_ACK_T2: begin
        s_nxt.st = VIU_ST_ACK_TW;
        s_nxt.fetch_n = 1'b0;
        s_nxt.ioreq_n = 1'b0;
        s_nxt.wait_req = 1'b1;
      end
      VIU_ST_ACK_TW: begin
        s_nxt.fetch_n = 1'b0;
        s_nxt.ioreq_n = 1'b0;
        s_nxt.cnt = s_r.cnt - 3'h1;
        s_nxt.wait_req = (s_r.cnt > 3'h1);
        if (s_r.cnt == 3'h1) begin
          s_nxt.st = VIU_ST_ACK_T3;
        end
      end
      VIU_ST_ACK_T3: begin
        s_nxt.st = VIU_ST_IDLE;
        s_nxt.cpu.ack_busy = 1'b0;
        if (s_r.ack_mode2) begin
          s_nxt.cpu.take = 1'b1;
          s_nxt.cpu.push_pc = 1'b1;
          s_nxt.cpu.vec_read = 1'b1;
          s_nxt.cpu.target = {s_r.cpu.vector_page, i_data_bus};
        end else begin
          s_nxt.cpu.mode0_valid = 1'b1;
          s_nxt.cpu.mode0_instr = i_data_bus;
          // decoded by the CPU, which reports it as an undefined fetch.
        end
      end
      VIU_ST_REFETCH: begin
        s_nxt.cnt = s_r.cnt - 3'h1;
        if (s_r.cnt == 3'h1) begin
          s_nxt.st = VIU_ST_IDLE;
          s_nxt.cpu.return_from_maskable_refetch = 1'b0;
        end else begin
          s_nxt.fetch_n = 1'b0;
        end
      end
      default: begin
        s_nxt.st = VIU_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.st <= VIU_ST_IDLE;
      s_r.nmi_prev <= 1'b1;
      s_r.ite <= VIU_RST_ITE;
      s_r.vec_low <= VIU_RST_VEC_LOW;
      s_r.opmode <= VIU_RST_OPMODE;
      s_r.reloc <= VIU_RST_RELOC;
      s_r.irq_mode <= VIU_RST_MODE;
      s_r.cpu.vector_page <= VIU_RST_VEC_PAGE;
      s_r.fetch_n <= 1'b1;
      s_r.ioreq_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs straight from the state register.
  // ----------------------------------------------------------------------------
  assign o_io_rdata = s_r.rdata;
  assign o_io_hit = s_r.hit;
  assign o_cpu = s_r.cpu;
  assign o_opcode_fetch_strobe_n = s_r.fetch_n;
  assign o_io_request_strobe_n = s_r.ioreq_n;
  assign o_wait_req = s_r.wait_req;

endmodule : viu_core

// *** viu_pkg.sv ***
// Purpose: Shared constants, types and helpers of the vectored interrupt unit.
// Assumes: One system clock; the CPU core decodes instructions and reports events.
// Notes:   Offsets are the 6-bit positions inside the relocatable internal I/O page.
package viu_pkg;

  // ----------------------------------------------------------------------------
  // Internal I/O page and register offsets
  // ----------------------------------------------------------------------------
  localparam logic [5:0] VIU_OFF_VEC_LOW = 6'h33;
  localparam logic [5:0] VIU_OFF_TRAP_CTL = 6'h34;
  localparam logic [5:0] VIU_OFF_OPMODE = 6'h3E;
  localparam logic [5:0] VIU_OFF_IOCTL = 6'h3F;
  localparam logic [7:0] VIU_IO_PAGE_HI = 8'h00;

  // ----------------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------------
  localparam int VIU_TC_TRAP = 7;
  localparam int VIU_TC_UFO = 6;
  localparam int VIU_TC_EN2 = 2;
  localparam int VIU_TC_EN1 = 1;
  localparam int VIU_TC_EN0 = 0;
  localparam logic [7:0] VIU_TC_FIXED_ONES = 8'h38;
  localparam int VIU_OPM_FULL_FETCH = 7;
  localparam logic [7:0] VIU_RST_VEC_LOW = 8'h00;
  localparam logic [2:0] VIU_RST_ITE = 3'h1;
  localparam logic [7:0] VIU_RST_OPMODE = 8'hFF;
  localparam logic [1:0] VIU_RST_RELOC = 2'h0;
  localparam logic [7:0] VIU_RST_VEC_PAGE = 8'h00;
  localparam logic [1:0] VIU_RST_MODE = 2'h0;

  // ----------------------------------------------------------------------------
  // Restart addresses, opcodes and timing counts
  // ----------------------------------------------------------------------------
  localparam logic [15:0] VIU_ADDR_TRAP = 16'h0000;
  localparam logic [15:0] VIU_ADDR_NMI = 16'h0066;
  localparam logic [15:0] VIU_ADDR_MODE1 = 16'h0038;
  localparam logic [7:0] VIU_OP_PREFIX_ED = 8'hED;
  localparam logic [7:0] VIU_OP_RET_MASKABLE = 8'h4D;
  localparam logic [2:0] VIU_ACK_WAITS = 3'h2;
  localparam logic [2:0] VIU_REFETCH_TSTATES = 3'h4;
  localparam int VIU_RETURN_FROM_MASKABLE_TSTATES = 22;
  localparam int VIU_RETURN_FROM_MASKABLE_MCYCLES = 10;
  localparam int VIU_NUM_VEC = 9;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    VIU_ST_IDLE = 3'b000,
    VIU_ST_ACK_T1 = 3'b001,
    VIU_ST_ACK_T2 = 3'b010,
    VIU_ST_ACK_TW = 3'b011,
    VIU_ST_ACK_T3 = 3'b100,
    VIU_ST_REFETCH = 3'b101
  } viu_state_t;

  // Events reported by the CPU core, one-cycle pulses on the system clock.
  typedef struct packed {
    logic sample;        // Interrupt sampling point of the current machine cycle.
    logic fetch;         // An opcode byte was fetched.
    logic [7:0] fetch_byte;
    logic fetch_undef;   // The fetched byte completes an undefined opcode.
    logic undef_second;  // The undefined byte was the second opcode byte.
    logic m1_cycle;      // An opcode fetch cycle is running.
    logic enable_instr;
    logic disable_instr;
    logic ret_nmi_instr;
    logic mode_sel;
    logic [1:0] mode_val;
    logic ld_vec_page;
    logic [7:0] acc;
    logic ld_acc_ir;
  } viu_cpu_evt_t;

  // Answer to the CPU core.
  typedef struct packed {
    logic take;          // One-cycle pulse: a response sequence starts.
    logic push_pc;       // With take: stack the program counter.
    logic jump;          // With take: continue at target.
    logic vec_read;      // With take: read 16-bit restart address at target.
    logic [15:0] target;
    logic mode0_valid;   // Pulse: execute mode0_instr from the acknowledge.
    logic [7:0] mode0_instr;
    logic ack_busy;      // Level: CPU holds off while the acknowledge runs.
    logic return_from_maskable_refetch;  // Level: return-from-maskable refetch in progress.
    logic dma_master_clear;
    logic global_irq_enable_flag;
    logic saved_irq_enable_flag;
    logic pv_flag;
    logic [7:0] vector_page;
  } viu_cpu_out_t;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Fixed low code of vectored source idx, highest priority first.
  function automatic logic [4:0] viu_fixed_code(input logic [3:0] idx);
    viu_fixed_code = {idx, 1'b0};
  endfunction : viu_fixed_code

  // Index of the highest-priority pending vectored source.
  function automatic logic [3:0] viu_first(input logic [VIU_NUM_VEC-1:0] req);
    viu_first = 4'h0;
    for (int k = VIU_NUM_VEC - 1; k >= 0; k--) begin
      if (req[k]) begin
        viu_first = 4'(k);
      end
    end
  endfunction : viu_first

endpackage : viu_pkg

// *** viu_sync.sv ***
// Purpose: Two-stage synchroniser for the external request pins.
// Assumes: Pins are asynchronous to the system clock.
// Notes:   Only the second stage is visible; the first stage feeds nothing else.
`timescale 1ns/100ps
module viu_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Pins and synchronised copy
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------------------
  // Two flip-flops; the idle level of the low-active pins is high.
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= '1;
      o_sync <= '1;
    end else begin
      meta_r <= i_pin;
      o_sync <= meta_r;
    end
  end

endmodule : viu_sync

// *** viu_core_asserts.sv ***
// Purpose: Concurrent checks on the interrupt unit ports.
// Assumes: One clock domain, reset active high.
// Notes:   Attached by bind from the bench top file.
`timescale 1ns/100ps
module viu_core_asserts
  import viu_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Watched inputs
  input wire viu_cpu_evt_t i_evt,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_rd,
  // Watched outputs
  input wire logic [7:0] o_io_rdata,
  input wire logic o_io_hit,
  input wire viu_cpu_out_t o_cpu,
  input wire logic o_opcode_fetch_strobe_n,
  input wire logic o_io_request_strobe_n,
  input wire logic o_wait_req
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // Short names for the two enable flags.
  wire g = o_cpu.global_irq_enable_flag;
  wire s = o_cpu.saved_irq_enable_flag;
  property p_trap;
    i_evt.fetch && i_evt.fetch_undef |=> o_cpu.take && o_cpu.push_pc && o_cpu.jump
      && o_cpu.target == 16'h0000;
  endproperty
  a_trap: assert property (p_trap) else $error("trap answer wrong");
  property p_nmi;
    o_cpu.dma_master_clear |-> o_cpu.take && o_cpu.target == 16'h0066 && !g && s == $past(g);
  endproperty
  a_nmi: assert property (p_nmi) else $error("nonmaskable answer wrong");
  property p_ret_nmi;
    i_evt.ret_nmi_instr |=> g == $past(s) && $stable(s);
  endproperty
  a_ret_nmi: assert property (p_ret_nmi) else $error("return flags wrong");
  property p_enable;
    i_evt.enable_instr |=> g && s;
  endproperty
  a_enable: assert property (p_enable) else $error("enable flags wrong");
  property p_disable;
    i_evt.disable_instr |=> !g && !s;
  endproperty
  a_disable: assert property (p_disable) else $error("disable flags wrong");
  property p_mask;
    i_evt.sample && !g && !o_cpu.ack_busy |=> !o_cpu.ack_busy && !(o_cpu.take && o_cpu.vec_read);
  endproperty
  a_mask: assert property (p_mask) else $error("masked request served");
  property p_clear;
    o_cpu.take && (o_cpu.vec_read || o_cpu.target == 16'h0038) |-> !g && !s;
  endproperty
  a_clear: assert property (p_clear) else $error("flags kept on accept");
  property p_ack;
    $rose(o_cpu.ack_busy) |-> !o_opcode_fetch_strobe_n
      ##1 (!o_opcode_fetch_strobe_n && !o_io_request_strobe_n && o_wait_req) [*2]
      ##1 o_wait_req ##1 !o_wait_req ##1 (o_cpu.take || o_cpu.mode0_valid);
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge cycle wrong");
  property p_return_from_maskable;
    $rose(o_cpu.return_from_maskable_refetch) |-> (o_cpu.return_from_maskable_refetch && !o_opcode_fetch_strobe_n) [*4]
      ##1 !o_cpu.return_from_maskable_refetch;
  endproperty
  a_return_from_maskable: assert property (p_return_from_maskable) else $error("refetch length wrong");
  property p_pv;
    i_evt.ld_acc_ir |=> o_cpu.pv_flag == $past(s);
  endproperty
  a_pv: assert property (p_pv) else $error("parity flag wrong");
  property p_miss;
    i_io_rd && i_io_addr[5:0] == 6'h35 |=> !o_io_hit && o_io_rdata == 8'h00;
  endproperty
  a_miss: assert property (p_miss) else $error("unmapped read answered");
endmodule : viu_core_asserts

// *** viu_periph_model.sv ***
// Purpose: External peripheral answering acknowledge cycles on the data bus.
// Assumes: Strobes are active low and registered by the unit.
// Notes:   Off the acknowledge the bus shows a pattern that flips every cycle.
`timescale 1ns/100ps
module viu_periph_model (
  // Clock and strobes
  input wire logic i_clk_sys,
  input wire logic i_fetch_n,
  input wire logic i_ioreq_n,
  // Answer byte and bus
  input wire logic [7:0] i_resp,
  output logic [7:0] o_data
);
  logic drive_r = 1'b0;
  logic [7:0] data_r = 8'h00;
  assign o_data = data_r;
  always @(negedge i_clk_sys) begin
    drive_r <= !i_fetch_n && (!i_ioreq_n || drive_r);
    data_r <= (!i_fetch_n && (!i_ioreq_n || drive_r)) ? i_resp : ~data_r;
  end
endmodule : viu_periph_model

// *** test_vectored_interrupt_unit.sv ***
// Purpose: Self-checking bench of the interrupt unit.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Each event pulse spans exactly one rising edge.
`timescale 1ns/100ps
module test_vectored_interrupt_unit;
  import viu_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] pin = 4'hF;
  logic [6:0] preq = 7'h00;
  logic [6:0] pen = 7'h7F;
  logic [7:0] resp = 8'h00;
  logic [7:0] bus;
  logic [7:0] rdata;
  logic [7:0] wdata = 8'h00;
  logic [15:0] addr = 16'h0000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic hit, fetch_n, ioreq_n;
  viu_cpu_evt_t evt = '0;
  viu_cpu_evt_t e = '0;
  viu_cpu_out_t cpu;
  int num_errors = 0;
  int check_count = 0;
  wire [15:0] flg = {14'h0, cpu.global_irq_enable_flag, cpu.saved_irq_enable_flag};
  // Clock of 10 ns period.
  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  viu_core viu_core_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_nonmaskable_n(pin[3]),
    .i_maskable_request_level0_n(pin[2]), .i_maskable_request_level1_n(pin[1]),
    .i_maskable_request_level2_n(pin[0]), .i_data_bus(bus), .i_periph_req(preq),
    .i_periph_en(pen), .i_evt(evt), .i_io_addr(addr), .i_io_rd(rd), .i_io_wr(wr),
    .i_io_wdata(wdata), .o_io_rdata(rdata), .o_io_hit(hit), .o_cpu(cpu),
    .o_opcode_fetch_strobe_n(fetch_n), .o_io_request_strobe_n(ioreq_n), .o_wait_req());
  viu_periph_model viu_periph_model_i (.i_clk_sys(i_clk_sys), .i_fetch_n(fetch_n),
    .i_ioreq_n(ioreq_n), .i_resp(resp), .o_data(bus));
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    check_count++;
    if (g !== x) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  // Drives the pending event for one rising edge, then clears it.
  task automatic go();
    @(negedge i_clk_sys);
    evt = e;
    @(negedge i_clk_sys);
    evt = '0;
    e = '0;
  endtask : go
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    {wr, rd, addr, wdata} = {w, !w, a, d};
    @(negedge i_clk_sys);
    {wr, rd} = 2'b00;
  endtask : io
  task automatic rdc(input logic [15:0] a, input logic [7:0] x, input logic h);
    io(1'b0, a, 8'h00);
    chk("io_rdata", {8'h00, x}, {8'h00, rdata});
    chk("io_hit", {15'h0, h}, {15'h0, hit});
  endtask : rdc
  // Pins pass a two-stage synchroniser, so three edges are let by.
  task automatic pins(input logic [3:0] p, input logic [6:0] r);
    pin = p;
    preq = r;
    repeat (3) @(negedge i_clk_sys);
  endtask : pins
  task automatic enable_sample();
    e.enable_instr = 1'b1;
    go();
    e.sample = 1'b1;
    go();
  endtask : enable_sample
  task automatic wt();
    int n = 0;
    while (cpu.take !== 1'b1 && cpu.mode0_valid !== 1'b1) begin
      if (n++ > 12) begin
        $display("unexpected wait expected answer seen none");
        num_errors++;
        tally_and_finish();
      end
      @(negedge i_clk_sys);
    end
  endtask : wt
  // Hang guard.
  initial begin
    repeat (5000) @(negedge i_clk_sys);
    num_errors++;
    tally_and_finish();
  end
  // Main sequence.
  initial begin
    repeat (12) @(negedge i_clk_sys);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    rdc(16'h0033, 8'h00, 1'b1);
    rdc(16'h0034, 8'h39, 1'b1);
    rdc(16'h003E, 8'hFF, 1'b1);
    rdc(16'h003F, 8'h1F, 1'b1);
    rdc(16'h0035, 8'h00, 1'b0);
    chk("reset_flags", 16'h0, flg);
    e.fetch = 1'b1;
    e.fetch_undef = 1'b1;
    e.fetch_byte = 8'hDD;
    go();
    chk("trap_target", VIU_ADDR_TRAP, cpu.target);
    rdc(16'h0034, 8'hB9, 1'b1);
    io(1'b1, 16'h0034, 8'h07);
    rdc(16'h0034, 8'h3F, 1'b1);
    io(1'b1, 16'h0033, 8'hE7);
    rdc(16'h0033, 8'hE0, 1'b1);
    e.ld_vec_page = 1'b1;
    e.acc = 8'h12;
    go();
    chk("page", 16'h0012, {8'h00, cpu.vector_page});
    // Mode 0 straight from reset, the peripheral offers a restart opcode.
    resp = 8'hFF;
    pins(4'hB, 7'h00);
    enable_sample();
    wt();
    chk("mode0", 16'h1FF, {7'h0, cpu.mode0_valid, cpu.mode0_instr});
    chk("mode0_push", 16'h0, {14'h0, cpu.take, cpu.push_pc});
    // The core reports the acknowledged byte as undefined, so the trap follows.
    e.fetch = 1'b1;
    e.fetch_undef = 1'b1;
    go();
    chk("mode0_trap", 16'h3, {14'h0, cpu.take, cpu.jump});
    for (int m = 1; m < 3; m++) begin
      e.mode_sel = 1'b1;
      e.mode_val = 2'(m);
      go();
      resp = 8'h5A;
      enable_sample();
      wt();
      chk("mode_target", m == 1 ? VIU_ADDR_MODE1 : 16'h125A, cpu.target);
      chk("mode_take", 16'h3, {14'h0, cpu.take, cpu.push_pc});
      chk("mode_flags", 16'h0, flg);
    end
    // Every vectored source alone, highest priority first.
    for (int k = 0; k < 9; k++) begin
      pins({2'b11, k != 0, k != 1}, k > 1 ? 7'(1 << (k - 2)) : 7'h00);
      enable_sample();
      chk("vec_take", 16'h3, {14'h0, cpu.take, cpu.vec_read});
      chk("vec_target", {8'h12, 3'b111, 5'(k * 2)}, cpu.target);
      chk("vec_flags", 16'h0, flg);
    end
    pins(4'hE, 7'h01);
    enable_sample();
    chk("prio_vec", 16'h12E2, cpu.target);
    pins(4'h5, 7'h00);
    enable_sample();
    chk("prio_nmi", VIU_ADDR_NMI, cpu.target);
    chk("nmi_dma", 16'h3, {14'h0, cpu.dma_master_clear, cpu.jump});
    chk("nmi_flags", 16'h1, flg);
    e.ld_acc_ir = 1'b1;
    go();
    chk("pv", 16'h1, {15'h0, cpu.pv_flag});
    pins(4'hF, 7'h00);
    e.ret_nmi_instr = 1'b1;
    go();
    chk("ret_nmi_flags", 16'h3, flg);
    e.disable_instr = 1'b1;
    go();
    pins(4'h7, 7'h00);
    e.sample = 1'b1;
    go();
    chk("nmi_masked_flag", {15'h0, 1'b1}, {15'h0, cpu.take});
    // Global flag low, then level-0 and peripheral enables low.
    pins(4'hB, 7'h7F);
    e.sample = 1'b1;
    go();
    chk("mask_global", 16'h0, {14'h0, cpu.take, cpu.ack_busy});
    pen = 7'h00;
    io(1'b1, 16'h0034, 8'h06);
    enable_sample();
    chk("mask_each", 16'h0, {14'h0, cpu.take, cpu.ack_busy});
    pins(4'hF, 7'h00);
    io(1'b1, 16'h003E, 8'h7F);
    e.fetch = 1'b1;
    e.fetch_byte = VIU_OP_PREFIX_ED;
    go();
    e.fetch = 1'b1;
    e.fetch_byte = VIU_OP_RET_MASKABLE;
    go();
    chk("refetch", 16'h1, {15'h0, cpu.return_from_maskable_refetch});
    io(1'b1, 16'h003F, 8'hC0);
    rdc(16'h00F4, 8'h3E, 1'b1);
    rdc(16'h0034, 8'h00, 1'b0);
    tally_and_finish();
  end
endmodule : test_vectored_interrupt_unit
bind viu_core viu_core_asserts viu_core_asserts_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_evt(i_evt), .i_io_addr(i_io_addr), .i_io_rd(i_io_rd), .o_io_rdata(o_io_rdata),
  .o_io_hit(o_io_hit), .o_cpu(o_cpu), .o_opcode_fetch_strobe_n(o_opcode_fetch_strobe_n),
  .o_io_request_strobe_n(o_io_request_strobe_n), .o_wait_req(o_wait_req));
